// ==== sdb_core.sv ====
// sdb_core.sv: status flags, data buffering and master shift engine, AXI4-Lite slave
// assumes one clock aclk; pins arrive raw and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "sdb_params.svh"
module sdb_core
  #(parameter logic [7:0] HALF_CYC = 8'(`SDB_SCK_HALF_CYC))
  (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire sdb_pkg::sdb_axi_req_t axi_req,
  output var sdb_pkg::sdb_axi_rsp_t axi_rsp,
  // link pins
  input wire sdb_pkg::sdb_pin_in_t pin_in,
  output var sdb_pkg::sdb_pin_out_t pin_out
  );
  import sdb_pkg::*;

  sdb_state_t st;
  sdb_state_t next_st;
  logic [1:0] pin_s;
  logic wide;
  logic wr_go;
  logic rd_go;
  logic rx_take;
  logic tx_take;
  logic done;
  logic mf_event;
  logic [5:0] widx;
  logic [5:0] ridx;

  function automatic logic [3:0] sdb_msb(input logic w);
    return w ? 4'hF : 4'h7;
  endfunction : sdb_msb

  // 8-bit width keeps only the low byte
  function automatic logic [15:0] sdb_cut(input logic [15:0] s, input logic w);
    return w ? s : {8'h00, s[7:0]};
  endfunction : sdb_cut

  // pin_s[1] is slave select, idle high
  sdb_sync #(.WIDTH(2), .RESET_VAL(`SDB_PIN_RESET)) u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({pin_in.ss_n, pin_in.miso}),
    .dout(pin_s)
  );

  assign wide = st.ctrl2[`SDB_C2_WIDTH];

  always_comb
  begin
    next_st = st;
    wr_go = st.aw_full && st.w_full && !st.bvalid;
    rd_go = axi_req.arvalid && st.arready;
    widx = st.waddr[7:2];
    ridx = axi_req.araddr[7:2];
    rx_take = 1'b0;
    tx_take = 1'b0;
    done = 1'b0;
    mf_event = st.ctrl1[`SDB_C1_MASTER] && st.ctrl2[`SDB_C2_FAULT_EN] && !pin_s[1];
    if (axi_req.awvalid && st.awready)
    begin
      next_st.aw_full = 1'b1;
      next_st.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.wready)
    begin
      next_st.w_full = 1'b1;
      next_st.wdata = axi_req.wdata[15:0];
      next_st.wstrb = axi_req.wstrb[1:0];
    end
    if (st.bvalid && axi_req.bready)
      next_st.bvalid = 1'b0;
    if (st.rvalid && axi_req.rready)
      next_st.rvalid = 1'b0;
    if (rd_go)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `SDB_RESP_OKAY;
      next_st.rdata = 16'h0000;
      case (ridx)
        `SDB_IDX_CTRL1: next_st.rdata = {8'h00, st.ctrl1};
        `SDB_IDX_CTRL2: next_st.rdata = {8'h00, st.ctrl2};
        `SDB_IDX_STATUS:
        begin
          next_st.rdata[`SDB_ST_RCV] = st.rcv;
          next_st.rdata[`SDB_ST_TXE] = st.txe;
          next_st.rdata[`SDB_ST_FAULT] = st.fault;
          next_st.arm_rx = st.rcv;
          next_st.arm_tx = st.txe;
          next_st.arm_fault = st.fault;
        end
        `SDB_IDX_DATA_HI: next_st.rdata = {8'h00, st.rx[15:8]};
        `SDB_IDX_DATA_LO:
        begin
          next_st.rdata = {8'h00, st.rx[7:0]};
          rx_take = 1'b1;
        end
        `SDB_IDX_DATA_WORD:
        begin
          next_st.rdata = st.rx;
          rx_take = 1'b1;
        end
        default: next_st.rresp = `SDB_RESP_SLVERR;
      endcase
    end
    if (rx_take && st.arm_rx)
    begin
      next_st.arm_rx = 1'b0;
      // held word survives only if no transfer has started since
      if (st.held)
      begin
        next_st.rx = sdb_cut(st.shreg, wide);
        next_st.held = 1'b0;
      end
      else
        next_st.rcv = 1'b0;
    end
    if (wr_go)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `SDB_RESP_OKAY;
      case (widx)
        `SDB_IDX_CTRL1:
        begin
          if (st.wstrb[0])
            next_st.ctrl1 = st.wdata[7:0];
          if (st.arm_fault)
          begin
            next_st.fault = 1'b0;
            next_st.arm_fault = 1'b0;
          end
        end
        `SDB_IDX_CTRL2:
          if (st.wstrb[0])
            next_st.ctrl2 = st.wdata[7:0];
        `SDB_IDX_STATUS: next_st.bresp = `SDB_RESP_OKAY;
        `SDB_IDX_DATA_HI:
          if (st.txe && st.wstrb[0])
            next_st.tx[15:8] = st.wdata[7:0];
        `SDB_IDX_DATA_LO:
          if (st.txe && st.wstrb[0])
          begin
            next_st.tx[7:0] = st.wdata[7:0];
            tx_take = 1'b1;
          end
        `SDB_IDX_DATA_WORD:
          if (st.txe && st.wstrb == 2'h3)
          begin
            next_st.tx = st.wdata;
            tx_take = 1'b1;
          end
        default: next_st.bresp = `SDB_RESP_SLVERR;
      endcase
    end
    if (tx_take && st.arm_tx)
    begin
      next_st.txe = 1'b0;
      next_st.arm_tx = 1'b0;
    end
    if (mf_event)
    begin
      next_st.fault = 1'b1;
      next_st.ctrl1[`SDB_C1_MASTER] = 1'b0;
      next_st.eng = SDB_IDLE;
      next_st.sck = 1'b0;
    end
    else
    begin
      case (st.eng)
        SDB_IDLE:
          if (st.ctrl1[`SDB_C1_MASTER] && !st.txe)
          begin
            next_st.eng = SDB_SHIFT;
            next_st.shreg = sdb_cut(st.tx, wide);
            next_st.mosi = st.tx[sdb_msb(wide)];
            next_st.txe = 1'b1;
            next_st.held = 1'b0;
            next_st.div = 8'h00;
            next_st.bits = 5'h00;
            next_st.sck = 1'b0;
          end
        SDB_SHIFT:
          if (st.div == HALF_CYC - 8'h01)
          begin
            next_st.div = 8'h00;
            next_st.sck = !st.sck;
            // sample on rising, drive next bit on falling
            if (!st.sck)
            begin
              next_st.shreg = {st.shreg[14:0], pin_s[0]};
              next_st.bits = st.bits + 5'h01;
            end
            else
            begin
              next_st.mosi = st.shreg[sdb_msb(wide)];
              if (st.bits == 5'(sdb_msb(wide)) + 5'h01)
              begin
                next_st.eng = SDB_IDLE;
                done = 1'b1;
              end
            end
          end
          else
            next_st.div = st.div + 8'h01;
        default: next_st.eng = SDB_IDLE;
      endcase
    end
    if (done)
    begin
      // a clear in this same cycle loses to the new word
      if (!next_st.rcv)
      begin
        next_st.rx = sdb_cut(st.shreg, wide);
        next_st.rcv = 1'b1;
      end
      else
        next_st.held = 1'b1;
    end
    next_st.oe = next_st.ctrl1[`SDB_C1_MASTER];
    next_st.awready = !next_st.aw_full;
    next_st.wready = !next_st.w_full;
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.ctrl1 <= `SDB_CTRL_RESET;
      st.ctrl2 <= `SDB_CTRL_RESET;
      st.rx <= `SDB_DATA_RESET;
      st.tx <= `SDB_DATA_RESET;
      st.txe <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign axi_rsp.awready = st.awready;
  assign axi_rsp.wready = st.wready;
  assign axi_rsp.bvalid = st.bvalid;
  assign axi_rsp.bresp = st.bresp;
  assign axi_rsp.arready = st.arready;
  assign axi_rsp.rvalid = st.rvalid;
  assign axi_rsp.rdata = {16'h0000, st.rdata};
  assign axi_rsp.rresp = st.rresp;
  assign pin_out.sck = st.sck;
  assign pin_out.sck_oe = st.oe;
  assign pin_out.mosi = st.mosi;
  assign pin_out.mosi_oe = st.oe;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_fault_out;
    st.fault && !st.ctrl1[`SDB_C1_MASTER] && !st.oe && st.eng == SDB_IDLE;
  endsequence

  sequence s_moved;
    st.rcv && !st.held && st.rx == sdb_cut(st.shreg, wide);
  endsequence

  a_status_read: assert property (rd_go && ridx == `SDB_IDX_STATUS |=>
    st.rdata[`SDB_ST_RCV] == $past(st.rcv) && st.rdata[`SDB_ST_TXE] == $past(st.txe))
    else $error("status read does not show flags");
  a_rx_set: assert property (done && !st.rcv |=> s_moved)
    else $error("finished word not moved in");
  a_rx_hold: assert property (done && st.rcv && !(rx_take && st.arm_rx) |=> st.held && $stable(st.rx))
    else $error("second word not held");
  a_rx_clear: assert property (rx_take && st.arm_rx && !st.held && !done |=> !st.rcv)
    else $error("receive flag not cleared");
  a_held_move: assert property (rx_take && st.arm_rx && st.held |=> s_moved)
    else $error("held word not moved");
  a_hi_read: assert property (rd_go && ridx == `SDB_IDX_DATA_HI && !done |=> st.rcv == $past(st.rcv))
    else $error("high read changed flag");
  a_tx_ignore: assert property (wr_go && !st.txe |=> $stable(st.tx))
    else $error("write accepted while occupied");
  a_tx_clear: assert property (tx_take && st.arm_tx |=> !st.txe)
    else $error("transmit-empty not cleared");
  a_start_now: assert property (st.eng == SDB_IDLE && st.ctrl1[`SDB_C1_MASTER] && !st.txe && !mf_event
    |=> st.eng == SDB_SHIFT && st.txe && !st.held)
    else $error("queued word not started");
  a_fault_drop: assert property (mf_event |=> s_fault_out ##1 !st.sck)
    else $error("mode fault did not drop master");
  a_fault_clear: assert property (wr_go && widx == `SDB_IDX_CTRL1 && st.arm_fault && !mf_event |=> !st.fault)
    else $error("mode fault not cleared");
endmodule : sdb_core
`default_nettype wire

// ==== sdb_params.svh ====
// sdb_params.svh: register indices, field positions, reset values and timing counts of the serial status/data block
// assumes inclusion by sdb_pkg and sdb_core; byte address on the bus is four times the index
// Contract
// - status readable anytime; writes to status change nothing.
// - receive-complete flag, status bit 7, sets once data lands in data register.
// - status bit 5 reads 1 when transmit register empty, 0 when occupied.
// - mode-fault flag, bit 4, sets on slave-select low as master with detection enabled.
// - mode-fault flag clears on first-control write after status read saw it set.
// - receive flag clears only on low-byte read after status read saw it set; here a word read at index 6 clears it too.
// - in 16-bit width, high-byte reads never change the receive flag.
// - in 16-bit width, clearing by low-byte read alone loses the high byte.
// - transmit-empty clears only on low-byte write after status read saw it set; here a full word write at index 6 clears it too.
// - data writes while transmit-empty is 0 are ignored.
// - high-byte writes never touch transmit-empty; low-only write leaves high byte undefined.
// - data high at 0x4, low at 0x5; reset zero; reads receive, writes transmit.
// - master starts queued data right after the previous transfer completes.
// - transfer done with receive flag clear copies shift register in and sets flag.
// - second word while flag set stays held in shift register; data register unchanged.
// - flag serviced before next transfer starts moves held word in; flag stays set.
// - flag serviced after next transfer started drops held word.
// - one data address serves receive reads and transmit writes.
// - mode fault drops master select, disables outputs, aborts transfer to idle.
`ifndef SDB_PARAMS_SVH
`define SDB_PARAMS_SVH
`define SDB_IDX_CTRL1 6'h00
`define SDB_IDX_CTRL2 6'h01
`define SDB_IDX_STATUS 6'h03
`define SDB_IDX_DATA_HI 6'h04
`define SDB_IDX_DATA_LO 6'h05
`define SDB_IDX_DATA_WORD 6'h06
`define SDB_ST_RCV 7
`define SDB_ST_TXE 5
`define SDB_ST_FAULT 4
`define SDB_C1_MASTER 4
`define SDB_C2_FAULT_EN 4
`define SDB_C2_WIDTH 6
`define SDB_DATA_RESET 16'h0000
`define SDB_CTRL_RESET 8'h00
`define SDB_RESP_OKAY 2'h0
`define SDB_RESP_SLVERR 2'h2
`define SDB_PIN_RESET 2'h2
`define SDB_CLK_NS 4
`define SDB_SCK_HALF_NS 20
`define SDB_SCK_HALF_CYC (((`SDB_SCK_HALF_NS) + (`SDB_CLK_NS) - 1) / (`SDB_CLK_NS))
`endif

// ==== sdb_pkg.sv ====
// sdb_pkg.sv: types of the serial status/data block
// assumes sdb_params.svh on the include path
`include "sdb_params.svh"
package sdb_pkg;
  typedef enum logic {SDB_IDLE = 1'b0, SDB_SHIFT = 1'b1} sdb_eng_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } sdb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdb_axi_rsp_t;

  typedef struct packed {
    logic ss_n;
    logic miso;
  } sdb_pin_in_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
  } sdb_pin_out_t;

  typedef struct packed {
    logic aw_full;
    logic [7:0] waddr;
    logic w_full;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic rcv;
    logic txe;
    logic fault;
    logic arm_rx;
    logic arm_tx;
    logic arm_fault;
    logic held;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] shreg;
    sdb_eng_t eng;
    logic [7:0] div;
    logic [4:0] bits;
    logic sck;
    logic mosi;
    logic oe;
  } sdb_state_t;
endpackage : sdb_pkg

// ==== sdb_slave_model.sv ====
// sdb_slave_model.sv: behavioural link slave, mode 0, 16-bit words, msb first
// assumes sck idles low and mosi is steady at rising sck
`timescale 1ns/1ps
`default_nettype none
module sdb_slave_model
  (
  // link pins
  input wire logic sck,
  input wire logic sel,
  input wire logic mosi,
  output logic miso,
  // frame k answers reply plus k
  input wire logic [15:0] reply,
  output logic [15:0] got,
  output int frames
  );
  logic [15:0] sh = 16'h0000;
  logic [15:0] rx = 16'h0000;
  logic [15:0] nxt;
  logic last = 1'b0;
  int n = 0;
  initial got = 16'h0000;
  initial frames = 0;
  assign nxt = reply + 16'(frames);
  // released line shows inverse of its last bit, never a stale copy
  assign miso = sel ? (n == 0 ? nxt[15] : sh[15]) : ~last;
  always @(posedge sck)
  begin
    if (n == 0)
      sh = nxt;
    rx = {rx[14:0], mosi};
    n = n + 1;
  end
  always @(negedge sck)
  begin
    last = sh[15];
    sh = sh << 1;
    if (n == 16)
    begin
      got = rx;
      frames = frames + 1;
      n = 0;
    end
  end
  // an aborted frame restarts from its first bit
  always @(negedge sel)
    n = 0;
endmodule : sdb_slave_model
`default_nettype wire

// ==== sdb_sync.sv ====
// sdb_sync.sv: two-flop synchroniser for the link input pins
// assumes inputs asynchronous to aclk; reset level per bit is a parameter
`timescale 1ns/1ps
`default_nettype none
module sdb_sync
  #(parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0)
  (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw and synchronised levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
  );
  logic [WIDTH-1:0] meta;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : sdb_sync
`default_nettype wire

// ==== tb_top.sv ====
// tb_top.sv: register-level bench of sdb_core against a link slave model
// assumes sdb_params.svh, sdb_pkg and the design compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sdb_params.svh"
module tb_top;
  import sdb_pkg::*;
  localparam logic [5:0] C1 = `SDB_IDX_CTRL1;
  localparam logic [5:0] C2 = `SDB_IDX_CTRL2;
  localparam logic [5:0] ST = `SDB_IDX_STATUS;
  localparam logic [5:0] HI = `SDB_IDX_DATA_HI;
  localparam logic [5:0] LO = `SDB_IDX_DATA_LO;
  localparam logic [5:0] DW = `SDB_IDX_DATA_WORD;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ss_n = 1'b1;
  logic miso;
  logic [15:0] got;
  int frames;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] d;
  logic [31:0] resp;
  sdb_axi_req_t req = '0;
  sdb_axi_rsp_t rsp;
  sdb_pin_in_t pin_in;
  sdb_pin_out_t pin_out;
  assign pin_in = '{ss_n: ss_n, miso: miso};
  always #2 aclk = ~aclk;
  // short sck half period keeps frames brief
  sdb_core #(.HALF_CYC(8'h04)) sdb_core_i (.aclk(aclk), .aresetn(aresetn),
    .axi_req(req), .axi_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out));
  sdb_slave_model sdb_slave_model_i (.sck(pin_out.sck), .sel(pin_out.sck_oe),
    .mosi(pin_out.mosi), .miso(miso), .reply(16'hBEE0), .got(got), .frames(frames));

  task automatic give_verdict;
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      failures++;
    end
  endtask : chk

  task automatic tmo(input string nm);
    failures++;
    $display("Error %s expected done seen timeout", nm);
    give_verdict();
  endtask : tmo

  task automatic wr(input logic [5:0] idx, input logic [31:0] v, input logic [3:0] s);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= s;
    req.bready <= 1'b1;
    for (int t = 0; t < 40 && !done; t++)
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        resp = {30'h0, rsp.bresp};
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      tmo("write");
  endtask : wr

  task automatic rd(input logic [5:0] idx, output logic [31:0] v);
    bit done;
    done = 1'b0;
    v = '0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    for (int t = 0; t < 40 && !done; t++)
    begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        v = rsp.rdata;
        resp = {30'h0, rsp.rresp};
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      tmo("read");
  endtask : rd

  task automatic rchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    rd(idx, v);
    chk(nm, v, exp);
  endtask : rchk

  // margin lets the device finish its copy after the last sck fall
  task automatic wait_frames(input int n);
    for (int t = 0; t < 4000 && frames < n; t++)
      @(posedge aclk);
    if (frames < n)
      tmo("frames");
    repeat (8) @(posedge aclk);
  endtask : wait_frames

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("status", ST, 32'h20);
    rchk("data_high", HI, 32'h0);
    rchk("data_low", LO, 32'h0);
    wr(ST, 32'hFF, 4'hF);
    chk("status_bresp", resp, 32'h0);
    rchk("status", ST, 32'h20);
    wr(6'h07, 32'h1, 4'hF);
    chk("unmapped_bresp", resp, 32'h2);
    rd(6'h07, d);
    chk("unmapped_rresp", resp, 32'h2);
    wr(C2, 32'h40, 4'h1);
    wr(HI, 32'h3C, 4'h1);
    rchk("status", ST, 32'h20);
    wr(LO, 32'hA5, 4'h1);
    rchk("status", ST, 32'h0);
    wr(HI, 32'h77, 4'h1);
    wr(LO, 32'h11, 4'h1);
    rchk("status", ST, 32'h0);
    wr(C1, 32'h10, 4'h1);
    wait_frames(1);
    chk("slave_got", {16'h0, got}, 32'h3CA5);
    rchk("status", ST, 32'hA0);
    rchk("data_high", HI, 32'hBE);
    rchk("data_high", HI, 32'hBE);
    rchk("status", ST, 32'hA0);
    rchk("data_low", LO, 32'hE0);
    rchk("status", ST, 32'h20);
    // two words back to back, flag left unserviced
    wr(DW, 32'h1234, 4'h3);
    rd(ST, d);
    wr(DW, 32'h5678, 4'h3);
    wait_frames(3);
    chk("slave_got", {16'h0, got}, 32'h5678);
    rchk("data_word", DW, 32'hBEE1);
    rchk("status", ST, 32'hA0);
    rchk("data_low", LO, 32'hE1);
    rchk("status", ST, 32'hA0);
    rchk("data_word", DW, 32'hBEE2);
    rchk("status", ST, 32'h20);
    // held word serviced only after a third frame began
    wr(DW, 32'h0001, 4'h3);
    rd(ST, d);
    wr(DW, 32'h0002, 4'h3);
    wait_frames(5);
    rd(ST, d);
    wr(DW, 32'h0003, 4'h3);
    rchk("data_low", LO, 32'hE3);
    rchk("status", ST, 32'h20);
    wait_frames(6);
    rchk("data_word", DW, 32'hBEE5);
    // mode fault in mid-frame
    wr(C2, 32'h50, 4'h1);
    rd(ST, d);
    wr(DW, 32'h00AA, 4'h3);
    repeat (12) @(posedge aclk);
    ss_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("pin_oe", {30'h0, pin_out.sck_oe, pin_out.mosi_oe}, 32'h0);
    ss_n <= 1'b1;
    rchk("ctrl1", C1, 32'h0);
    rchk("status", ST, 32'hB0);
    wr(C1, 32'h0, 4'h1);
    rchk("status", ST, 32'hA0);
    rchk("data_word", DW, 32'hBEE5);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
